// ===== shared/sysacc_defs.vh
// Register map, field positions and timing counts of the system access unit
`ifndef SYSACC_DEFS_VH
`define SYSACC_DEFS_VH
// ============================================================
// Register byte offsets
`define OFS_COMMAND    6'h00
`define OFS_STATUS     6'h04
`define OFS_STATCLR    6'h08
`define OFS_ADDR       6'h0c
`define OFS_LENGTH     6'h10
`define OFS_DATA       6'h14
`define OFS_REVISION   6'h28
// ============================================================
// Command bits
`define CMD_EN         0
`define CMD_DIS        1
`define CMD_CRC        2
`define CMD_FETCH      3
`define CMD_WIPE       4
// ============================================================
// Status bits
`define ST_DONE        0
`define ST_BUSERR      1
`define ST_HOLD        2
`define ST_PROT        3
`define ST_EN          4
`define ST_BUSY        5
// ============================================================
// Reset values, timing, revision fields and CRC polynomial
`define DATA_RESET     32'h0000_0000
`define WIPE_TIME_NS   400
`define WIPE_CYCLES    ((`WIPE_TIME_NS + 3) / 4)
`define REV_VARIANT    4'h0
`define REV_VERSION    12'h100
`define CRC_POLY       32'h04c1_1db7
`endif

// ===== design/sysacc.v
// System access unit: AHB-Lite registers driving wipe, user-row fetch and CRC
`default_nettype none
`include "sysacc_defs.vh"
// ============================================================
// What this block does
// RL1: A command bit written as zero has no effect at all.
// RL2: Command bit 4 starts a full wipe of memories, fuses and protection.
// RL3: The end of the wipe sets the done flag in the status register.
// RL4: Every action bit of the command register reads back as zero.
// RL5: Command bit 3 reads the user-row word at the address into data.
// RL6: The address register increments after each user-row read.
// RL7: The debugger waits for done high before reading the data register.
// RL8: Command bit 2 starts a CRC over the address and length range.
// RL9: The CRC command is refused while the chip is protected.
// RL10: Command bit 1 disables the unit and clears its internal state except the data register and the memory address.
// RL11: Command bit 0 enables the unit.
// RL12: The bus error flag is zero until a memory error sets it.
// RL13: The core-hold flag is one while the core is held in reset.
// RL14: The done flag is sticky and set by any finished operation.
// RL15: A 32-bit read/write data register at 0x14 resets to zero.
// RL16: A read-only revision register at 0x28 holds variant and version.
// RL17: While disabled, wipe, fetch and CRC commands are ignored; the code still runs them when they are written together with command bit 0.
module sysacc #(
  parameter WIPE_CYCLES = `WIPE_CYCLES
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        protected_state,
  input  wire        hold_cpu_in_reset,
  output reg         mem_req_q,
  output reg  [31:0] mem_addr_q,
  output reg         mem_user_row_q,
  input  wire        mem_ack,
  input  wire        mem_err,
  input  wire [31:0] mem_rdata,
  output reg         wipe_everything_op_q,
  input  wire        wipe_ack
);
  // ============================================================
  // Bus slave: zero wait states, always OKAY
  localparam S_IDLE  = 2'd0;
  localparam S_FETCH = 2'd1;
  localparam S_CRC   = 2'd2;
  localparam S_WIPE  = 2'd3;
  // Reserved fields of the revision word read as zero
  localparam [31:0] REV_WORD = {12'h000, `REV_VARIANT, 4'h0, `REV_VERSION};

  reg        wr_pend_q;
  reg [5:0]  ofs_q;
  reg        en_q;
  reg [1:0]  state_q;
  reg        done_q;
  reg        buserr_q;
  reg [31:0] addr_q;
  reg [31:0] length_q;
  reg [31:0] data_q;
  reg [31:0] crc_q;
  reg [31:0] left_q;
  reg [31:0] wipe_cnt_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_mux;
  reg [31:0] status_word;

  // ============================================================
  // Command decode; all writes act in the data phase
  wire take = hsel & hready & htrans[1];
  wire wr_cmd = wr_pend_q & (ofs_q == `OFS_COMMAND);
  wire wr_clr = wr_pend_q & (ofs_q == `OFS_STATCLR);
  wire go_en = wr_cmd & hwdata[`CMD_EN];                     // [RL11][RL1]
  wire go_dis = wr_cmd & hwdata[`CMD_DIS];                   // [RL10]
  wire en_now = en_q | go_en;
  wire idle = (state_q == S_IDLE);
  // Wipe wins over fetch, and fetch over CRC, within one write
  wire go_wipe = wr_cmd & hwdata[`CMD_WIPE] & en_now & idle; // [RL17]
  wire go_fetch = wr_cmd & hwdata[`CMD_FETCH] & en_now & idle & ~go_wipe;
  wire go_crc = wr_cmd & hwdata[`CMD_CRC] & en_now & idle
                & ~go_wipe & ~go_fetch & ~protected_state;   // [RL9]
  wire op_end = (state_q == S_WIPE & wipe_ack & wipe_cnt_q == 32'h0)
              | (state_q == S_FETCH & mem_ack)
              | (state_q == S_CRC & mem_ack & left_q == 32'h1)
              | (state_q == S_CRC & mem_ack & mem_err);

  // ============================================================
  // Write strobes and flag events
  // Range writes are dropped while busy so a running walk keeps its bounds
  wire wr_addr = wr_pend_q & (ofs_q == `OFS_ADDR) & idle;
  wire wr_length = wr_pend_q & (ofs_q == `OFS_LENGTH) & idle;
  wire wr_data = wr_pend_q & (ofs_q == `OFS_DATA);
  wire clr_done = wr_clr & hwdata[`ST_DONE];
  wire clr_buserr = wr_clr & hwdata[`ST_BUSERR];
  // A CRC of no words completes at once with the seed untouched
  wire crc_empty = go_crc & (length_q == 32'h0000_0000);
  wire crc_launch = go_crc & (length_q != 32'h0000_0000);    // [RL8]
  wire fetch_step = (state_q == S_FETCH) & mem_ack & ~go_dis;
  wire crc_step = (state_q == S_CRC) & mem_ack & ~go_dis;
  wire done_set = op_end | crc_empty;                        // [RL3]
  wire buserr_set = mem_ack & mem_err & ~idle;               // [RL12]

  // ============================================================
  // Bus response; every access completes at once, so no stalls to track
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ============================================================
  // Address phase capture; the map repeats every 64 bytes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      ofs_q <= 6'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      ofs_q <= haddr[5:0];
    end
  end

  // ============================================================
  // Status word; hold and protect are live pins, not stored copies
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_DONE] = done_q;                          // [RL14]
    status_word[`ST_BUSERR] = buserr_q;                      // [RL12]
    status_word[`ST_HOLD] = hold_cpu_in_reset;               // [RL13]
    status_word[`ST_PROT] = protected_state;
    status_word[`ST_EN] = en_q;
    status_word[`ST_BUSY] = ~idle;
  end

  // ============================================================
  // Read mux: data taken at the address phase, presented in data phase
  always @* begin
    case (haddr[5:0])
      `OFS_COMMAND: rd_mux = 32'h0000_0000;                  // [RL4]
      `OFS_STATUS: rd_mux = status_word;
      `OFS_ADDR: rd_mux = addr_q;
      `OFS_LENGTH: rd_mux = length_q;
      `OFS_DATA: rd_mux = data_q;                            // [RL15]
      `OFS_REVISION: rd_mux = REV_WORD;                      // [RL16]
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  // ============================================================
  // CRC-32 over one word, MSB first, one stage per data bit
  // A 32-stage ripple; acceptable for a slow debug path, not for speed
  wire [31:0] crc_stage [0:32];
  wire [31:0] crc_d;
  genvar b;
  assign crc_stage[0] = crc_q;
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_crc_bit
      assign crc_stage[b + 1] = {crc_stage[b][30:0], 1'b0}
                                ^ ({32{crc_stage[b][31] ^ mem_rdata[31 - b]}}
                                   & `CRC_POLY);
    end
  endgenerate
  assign crc_d = crc_stage[32];

  // ============================================================
  // Enable; a disable in the same write wins over an enable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
    end else if (go_dis) begin                               // [RL10]
      en_q <= 1'b0;
    end else if (go_en) begin
      en_q <= 1'b1;                                          // [RL11]
    end
  end

  // ============================================================
  // Sticky flags; an event beats a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      buserr_q <= 1'b0;
    end else if (go_dis) begin                               // [RL10]
      done_q <= 1'b0;
      buserr_q <= 1'b0;
    end else begin
      done_q <= done_set | (done_q & ~clr_done);             // [RL14]
      buserr_q <= buserr_set | (buserr_q & ~clr_buserr);     // [RL12]
    end
  end

  // ============================================================
  // Range registers; the fetch walks the address one word at a time
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 32'h0000_0000;
      length_q <= 32'h0000_0000;
    end else if (go_dis) begin                               // [RL10]
      addr_q <= 32'h0000_0000;
      length_q <= 32'h0000_0000;
    end else begin
      // A fetch step and an address write never meet: writes need idle
      if (fetch_step) begin
        addr_q <= addr_q + 32'h0000_0004;                    // [RL6]
      end else if (wr_addr) begin
        addr_q <= hwdata;
      end
      if (wr_length) begin
        length_q <= hwdata;
      end
    end
  end

  // ============================================================
  // Data word; survives a disable so a result can still be read out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q <= `DATA_RESET;                                 // [RL15]
    end else if (fetch_step) begin
      data_q <= mem_rdata;                                   // [RL5]
    end else if (crc_step) begin
      data_q <= crc_d;
    end else if (wr_data) begin
      data_q <= hwdata;
    end
  end

  // ============================================================
  // CRC accumulator and words left; seeded when a CRC is launched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= 32'h0000_0000;
      left_q <= 32'h0000_0000;
    end else if (go_dis) begin                               // [RL10]
      crc_q <= 32'h0000_0000;
      left_q <= 32'h0000_0000;
    end else if (crc_launch) begin
      crc_q <= 32'hffff_ffff;
      left_q <= length_q;
    end else if (crc_step) begin
      crc_q <= crc_d;
      left_q <= left_q - 32'h0000_0001;
    end
  end

  // ============================================================
  // Wipe pulse counter; minimum pulse before the array's report counts
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wipe_cnt_q <= 32'h0000_0000;
    end else if (go_dis) begin                               // [RL10]
      wipe_cnt_q <= 32'h0000_0000;
    end else if (go_wipe) begin
      wipe_cnt_q <= WIPE_CYCLES;
    end else if (wipe_cnt_q != 32'h0000_0000) begin
      wipe_cnt_q <= wipe_cnt_q - 32'h0000_0001;
    end
  end

  // ============================================================
  // Memory request; held until the memory answers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_user_row_q <= 1'b0;
    end else if (go_dis) begin                               // [RL10]
      mem_req_q <= 1'b0;
      mem_user_row_q <= 1'b0;
    end else if (go_fetch | crc_launch) begin
      mem_req_q <= 1'b1;
      mem_user_row_q <= go_fetch;                            // [RL5]
      mem_addr_q <= addr_q;
    end else if (op_end) begin
      mem_req_q <= 1'b0;
    end else if (crc_step) begin
      // Step on every word but the last so the next read is already queued
      mem_addr_q <= mem_addr_q + 32'h0000_0004;
    end
  end

  // ============================================================
  // Operation state; one operation at a time
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      wipe_everything_op_q <= 1'b0;
    end else if (go_dis) begin                               // [RL10]
      state_q <= S_IDLE;
      wipe_everything_op_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (go_wipe) begin
            state_q <= S_WIPE;                               // [RL2]
            wipe_everything_op_q <= 1'b1;
          end else if (go_fetch) begin
            state_q <= S_FETCH;                              // [RL5]
          end else if (crc_launch) begin
            state_q <= S_CRC;                                // [RL8]
          end
        end

        S_FETCH: begin
          if (mem_ack) begin
            state_q <= S_IDLE;
          end
        end

        S_CRC: begin
          if (mem_ack & (left_q == 32'h0000_0001 | mem_err)) begin
            state_q <= S_IDLE;
          end
        end

        S_WIPE: begin
          if (wipe_cnt_q == 32'h0000_0000 & wipe_ack) begin
            wipe_everything_op_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end

        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // sysacc
`default_nettype wire

// ===== test/sysacc_properties.sv
// Port-level checks for the system access unit
`default_nettype none
`include "sysacc_defs.vh"
module sysacc_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        protected_state,
  input wire logic        hold_cpu_in_reset,
  input wire logic        mem_req_q,
  input wire logic        mem_user_row_q,
  input wire logic        mem_ack,
  input wire logic        wipe_everything_op_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Data phase trackers
  logic       wc_q, rc_q, rs_q, rv_q;
  wire        ap = hsel & hready & htrans[1];
  wire        idle = !mem_req_q & !wipe_everything_op_q;
  wire  [4:0] c = hwdata[4:0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wc_q, rc_q, rs_q, rv_q} <= 4'h0;
    end else begin
      wc_q <= ap & hwrite & (haddr[5:0] == `OFS_COMMAND);
      rc_q <= ap & !hwrite & (haddr[5:0] == `OFS_COMMAND);
      rs_q <= ap & !hwrite & (haddr[5:0] == `OFS_STATUS);
      rv_q <= ap & !hwrite & (haddr[5:0] == `OFS_REVISION);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ============================================================
  // Properties
  property p_zero; wc_q && c == 5'h00 && idle |=> idle; endproperty
  a_zero: assert property (p_zero)
    else $error("zero command started work");
  property p_wipe;
    wc_q && c == 5'h11 && idle |=> wipe_everything_op_q [*2];
  endproperty
  a_wipe: assert property (p_wipe)
    else $error("wipe not started");
  property p_fetch;
    wc_q && c == 5'h09 && idle |=> mem_req_q && mem_user_row_q;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch not started");
  property p_prot;
    wc_q && c == 5'h05 && protected_state && idle |=> !mem_req_q;
  endproperty
  a_prot: assert property (p_prot)
    else $error("crc ran while protected");
  property p_dis; wc_q && c == 5'h02 |=> idle; endproperty
  a_dis: assert property (p_dis)
    else $error("disable left work running");
  property p_hold;
    mem_req_q && !mem_ack && !(wc_q && c[1]) |=> mem_req_q;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before ack");
  property p_cmd0; rc_q |-> hrdata == 32'h0000_0000; endproperty
  a_cmd0: assert property (p_cmd0)
    else $error("command reads non zero");
  property p_rev; rv_q |-> !hrdata[31:20] && !hrdata[15:12]; endproperty
  a_rev: assert property (p_rev)
    else $error("revision reserved bits set");
  property p_st; rs_q |-> hrdata[2] == $past(hold_cpu_in_reset); endproperty
  a_st: assert property (p_st)
    else $error("hold flag wrong");
endmodule // sysacc_properties
`default_nettype wire

// ===== test/mem_model.sv
// Memory and wipe responder behind the system access unit
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic        wipe,
  input  wire logic        err_on,
  input  wire logic        slow,
  output logic             ack,
  output logic             err,
  output logic             wack,
  output logic [31:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  initial {ack, err, wack, rdata} = 35'h0;
  // Read data is only valid with ack; otherwise it keeps changing
  always @(posedge clk) begin
    wack <= wipe;
    if (req && !ack && n >= (slow ? 3 : 0)) begin
      ack <= 1'b1;
      err <= err_on;
      rdata <= addr ^ 32'h5a5a_0000;
      n <= 0;
    end else begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= ~rdata;
      n <= req ? n + 1 : 0;
    end
  end
endmodule // mem_model
`default_nettype wire

// ===== test/sysacc_test.sv
// Self-checking bench for the system access unit
`default_nettype none
`include "sysacc_defs.vh"
module sysacc_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hwrite = 0, rdph = 0, slow = 0;
  logic        protected_state = 0, hold_cpu_in_reset = 1, err_on = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, x = 32'h2d7d, a, d;
  logic [31:0] q[$];
  wire  [31:0] hrdata, mem_addr_q, mem_rdata;
  wire         hreadyout, hresp, mem_req_q, mem_user_row_q, mem_ack;
  wire         mem_err, wipe_everything_op_q, wipe_ack;
  int          n_errors = 0, compares = 0;
  sysacc #(.WIPE_CYCLES(4)) i_sysacc (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .protected_state(protected_state),
    .hold_cpu_in_reset(hold_cpu_in_reset), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_user_row_q(mem_user_row_q),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .wipe_everything_op_q(wipe_everything_op_q), .wipe_ack(wipe_ack));
  mem_model i_mem_model (.clk(hclk), .req(mem_req_q), .addr(mem_addr_q),
    .wipe(wipe_everything_op_q), .err_on(err_on), .slow(slow),
    .ack(mem_ack), .err(mem_err), .wack(wipe_ack), .rdata(mem_rdata));
  always #2 hclk = ~hclk;
  // ============================================================
  // Bus master and result checking
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task bus(input logic w, input logic [5:0] ad, input logic [31:0] v);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {26'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task wr(input logic [5:0] ad, input logic [31:0] v);
    bus(1'b1, ad, v);
  endtask
  task rd(input logic [5:0] ad, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, e);
    end
  endtask
  always @(posedge hclk) begin
    if (rdph) chk(hrdata, q.pop_front());
    rdph <= htrans[1] & !hwrite;
  end
  // Waits until no request or wipe has been seen for four cycles
  task settle();
    int k;
    k = 0;
    while (k < 4) begin
      @(posedge hclk);
      k = (mem_req_q | wipe_everything_op_q) ? 0 : k + 1;
    end
  endtask
  task stop_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
  // ============================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`OFS_DATA, `DATA_RESET);
    rd(`OFS_REVISION, {12'h0, `REV_VARIANT, 4'h0, `REV_VERSION});
    rd(`OFS_COMMAND, 32'h0);
    rd(6'h3c, 32'h0);
    rd(`OFS_STATUS, 32'h04);
    a = rnd() & 32'h0000_00fc;
    wr(`OFS_ADDR, a);
    wr(`OFS_COMMAND, 32'h18);
    wr(`OFS_COMMAND, 32'h0);
    settle();
    rd(`OFS_STATUS, 32'h04);
    $display("reset and disabled tests done");
    hold_cpu_in_reset <= 1'b0;
    wr(`OFS_COMMAND, 32'h9);
    settle();
    rd(`OFS_STATUS, 32'h11);
    rd(`OFS_DATA, a ^ 32'h5a5a_0000);
    slow <= 1'b1;
    wr(`OFS_COMMAND, 32'h8);
    settle();
    rd(`OFS_DATA, (a + 4) ^ 32'h5a5a_0000);
    rd(`OFS_ADDR, a + 8);
    wr(`OFS_STATCLR, 32'h3);
    wr(`OFS_COMMAND, 32'h0);
    rd(`OFS_STATUS, 32'h10);
    $display("fetch tests done");
    protected_state <= 1'b1;
    wr(`OFS_LENGTH, 32'h1);
    wr(`OFS_COMMAND, 32'h5);
    settle();
    rd(`OFS_STATUS, 32'h18);
    protected_state <= 1'b0;
    err_on <= 1'b1;
    wr(`OFS_COMMAND, 32'h5);
    settle();
    rd(`OFS_STATUS, 32'h13);
    err_on <= 1'b0;
    wr(`OFS_STATCLR, 32'h3);
    wr(`OFS_COMMAND, 32'h11);
    settle();
    rd(`OFS_STATUS, 32'h11);
    $display("crc and wipe tests done");
    d = rnd();
    wr(`OFS_DATA, d);
    wr(`OFS_COMMAND, 32'h2);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_ADDR, 32'h0);
    rd(`OFS_DATA, d);
    $display("disable test done");
    stop_test();
  end
endmodule // sysacc_test
bind sysacc sysacc_properties i_sysacc_properties (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .protected_state(protected_state),
  .hold_cpu_in_reset(hold_cpu_in_reset), .mem_req_q(mem_req_q),
  .mem_user_row_q(mem_user_row_q), .mem_ack(mem_ack),
  .wipe_everything_op_q(wipe_everything_op_q));
`default_nettype wire
